/* File: design/intc_pkg.sv */
// Package for the eight-source interrupt controller: offsets, fields, reset values, types
package intc_pkg;

   // Wishbone word offsets (byte addresses)
   localparam logic [7:0] ADDR_ENABLE    = 8'h00;
   localparam logic [7:0] ADDR_PRIO_LOW  = 8'h04;
   localparam logic [7:0] ADDR_PRIO_HIGH = 8'h08;
   localparam logic [7:0] ADDR_EXT_CTRL  = 8'h0c;
   localparam logic [7:0] ADDR_FLAGS     = 8'h10;
   localparam logic [7:0] ADDR_CORE      = 8'h14;
   localparam logic [7:0] ADDR_EVT_STAT  = 8'h18;
   localparam logic [7:0] ADDR_EVT_MASK  = 8'h1c;

   // Reset values
   localparam logic [7:0] RST_ENABLE    = 8'h00;
   localparam logic [7:0] RST_PRIO_LOW  = 8'h00;
   localparam logic [7:0] RST_PRIO_HIGH = 8'h00;
   localparam logic [7:0] RST_EXT_CTRL  = 8'h00;
   localparam logic [7:0] RST_EVT_MASK  = 8'h00;

   // Enable register fields and low-priority write mask
   localparam int EN_GLOBAL_BIT = 7;
   localparam logic [7:0] ENABLE_MASK   = 8'hbf;
   localparam logic [7:0] PRIO_LOW_MASK = 8'h3f;

   // External control register fields (ext3 in high nibble, ext2 in low nibble)
   localparam int XC_PRIO_BIT = 3;
   localparam int XC_EN_BIT   = 2;
   localparam int XC_FLAG_BIT = 1;
   localparam int XC_TYPE_BIT = 0;
   localparam int XC_EXT2_LSB = 0;
   localparam int XC_EXT3_LSB = 4;

   // Flags register fields
   localparam int FL_EXT0   = 0;
   localparam int FL_EXT1   = 1;
   localparam int FL_T0     = 2;
   localparam int FL_T1     = 3;
   localparam int FL_T0TYPE = 4;
   localparam int FL_T1TYPE = 5;
   localparam int FL_RX     = 6;
   localparam int FL_TX     = 7;
   localparam int FL_T2OV   = 8;
   localparam int FL_T2EX   = 9;

   // Source indices in polling order
   localparam int NUM_SRC  = 8;
   localparam int SRC_EXT0 = 0;
   localparam int SRC_T0   = 1;
   localparam int SRC_EXT1 = 2;
   localparam int SRC_T1   = 3;
   localparam int SRC_SER  = 4;
   localparam int SRC_T2   = 5;
   localparam int SRC_EXT2 = 6;
   localparam int SRC_EXT3 = 7;

   // Vector of source n is base plus n times step
   localparam logic [7:0] VEC_BASE = 8'h03;
   localparam logic [7:0] VEC_STEP = 8'h08;

   // Event status bits
   localparam int EV_GRANT = 0;
   localparam int EV_RETI  = 1;

   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_OFFER  = 2'b01,
      ST_SERVE  = 2'b10
   } grant_state_t;

   // Result of arbitration
   typedef struct packed {
      logic       valid;
      logic [2:0] src;
      logic [1:0] level;
   } winner_t;

   // Grant presented to core
   typedef struct packed {
      logic       req;
      logic [7:0] vector;
      logic [1:0] level;
   } core_req_t;

endpackage

/* File: design/intc_arbiter.sv */
// Combinational arbiter: highest level, then fixed polling order
`timescale 1ns/100ps
module intc_arbiter #(
   parameter int N = 8
) (
   // Requests and levels
   input  wire logic [N-1:0]   pend_i,
   input  wire logic [2*N-1:0] level_i,
   // Preemption threshold
   input  wire logic           busy_i,
   input  wire logic [1:0]     floor_i,
   // Result
   output intc_pkg::winner_t   win_o
);

   always_comb begin
      win_o = '0;
      // Scan from last to first so the lowest index wins ties
      for (int i = N - 1; i >= 0; i--) begin
         if (pend_i[i] && (!win_o.valid || level_i[2*i +: 2] >= win_o.level)) begin
            win_o.valid = 1'b1;
            win_o.src   = 3'(i);
            win_o.level = level_i[2*i +: 2];
         end
      end
      // Only strictly higher levels preempt a routine in service
      if (busy_i && win_o.level <= floor_i) begin
         win_o.valid = 1'b0;
      end
   end

endmodule

/* File: design/intc_top.sv */
// Eight-source four-level interrupt controller with Wishbone register access
//
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
module intc_top #(
   parameter int NSRC = 8
) (
   // Clock and reset
   input  wire logic            clk_i,
   input  wire logic            rst_i,
   // Wishbone slave
   input  wire logic            cyc_i,
   input  wire logic            stb_i,
   input  wire logic            we_i,
   input  wire logic [7:0]      adr_i,
   input  wire logic [3:0]      sel_i,
   input  wire logic [31:0]     dat_i,
   output logic      [31:0]     dat_o,
   output logic                 ack_o,
   // External request pins, active low
   input  wire logic [3:0]      ext_int_n_i,
   // Peripheral flag sets, one-cycle pulses
   input  wire logic            timer0_ovf_i,
   input  wire logic            timer1_ovf_i,
   input  wire logic            timer2_ovf_i,
   input  wire logic            timer2_ext_i,
   input  wire logic            rx_done_i,
   input  wire logic            tx_done_i,
   // Core handshake
   input  wire logic            core_ack_i,
   input  wire logic            core_reti_i,
   output intc_pkg::core_req_t  core_o,
   // Controller event interrupt
   output logic                 irq_o
);

   typedef struct packed {
      logic [7:0]                 enable;
      logic [7:0]                 prio_low;
      logic [7:0]                 prio_high;
      logic [7:0]                 ext_ctrl;
      logic [1:0]                 ext01_flag;
      logic [1:0]                 ext01_type;
      logic [3:0]                 pin_prev;
      logic                       t0_flag;
      logic                       t1_flag;
      logic                       rx_flag;
      logic                       tx_flag;
      logic                       t2ov_flag;
      logic                       t2ex_flag;
      intc_pkg::grant_state_t     state;
      logic [2:0]                 cur_src;
      logic [3:0]                 in_service;
      logic [1:0]                 evt_stat;
      logic [1:0]                 evt_mask;
      logic [31:0]                rdata;
      logic                       ack;
      intc_pkg::core_req_t        core;
      logic                       irq;
   } state_t;

   state_t q, d;

   logic [NSRC-1:0]    pend;
   logic [2*NSRC-1:0]  level;
   logic [NSRC-1:0]    src_en;
   logic [3:0]         ext_flag;
   logic [3:0]         ext_type;
   logic               busy;
   logic [1:0]         floor_lvl;
   intc_pkg::winner_t  win;
   logic               wr;
   logic               rd;
   logic [7:0]         wb0;
   logic [15:0]        wb16;

   // Index of highest set in-service level
   function automatic logic [1:0] top_level(input logic [3:0] v);
      top_level = 2'd0;
      for (int i = 0; i < 4; i++) begin
         if (v[i]) begin
            top_level = 2'(i);
         end
      end
   endfunction

   // Merge byte lanes of a write onto an old value
   function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] wd,
                                              input logic [3:0] sel);
      lane_merge = old;
      if (sel[0]) begin
         lane_merge[7:0] = wd[7:0];
      end
      if (sel[1]) begin
         lane_merge[15:8] = wd[15:8];
      end
   endfunction

   // Byte lane 0 onto an old byte; every eight-bit register lives in that lane
   function automatic logic [7:0] lane_byte(input logic [7:0] old, input logic [31:0] wd, input logic [3:0] sel);
      lane_byte = sel[0] ? wd[7:0] : old;
   endfunction

   assign wr = cyc_i && stb_i && we_i && !q.ack;
   assign rd = cyc_i && stb_i && !we_i && !q.ack;
   assign wb0 = lane_byte(8'h00, dat_i, sel_i);
   // Flags register spans two lanes, so it is merged as a half word
   assign wb16 = lane_merge({6'h00, q.t2ex_flag, q.t2ov_flag, q.tx_flag, q.rx_flag, q.ext01_type, q.t1_flag,
                             q.t0_flag, q.ext01_flag}, dat_i, sel_i);

   // Per-source view of flags, enables and levels
   always_comb begin
      ext_flag = {q.ext_ctrl[intc_pkg::XC_EXT3_LSB + intc_pkg::XC_FLAG_BIT],
                  q.ext_ctrl[intc_pkg::XC_EXT2_LSB + intc_pkg::XC_FLAG_BIT],
                  q.ext01_flag};
      ext_type = {q.ext_ctrl[intc_pkg::XC_EXT3_LSB + intc_pkg::XC_TYPE_BIT],
                  q.ext_ctrl[intc_pkg::XC_EXT2_LSB + intc_pkg::XC_TYPE_BIT],
                  q.ext01_type};
      src_en = {q.ext_ctrl[intc_pkg::XC_EXT3_LSB + intc_pkg::XC_EN_BIT],
                q.ext_ctrl[intc_pkg::XC_EXT2_LSB + intc_pkg::XC_EN_BIT],
                q.enable[5:0]};
      pend = '0;
      if (q.enable[intc_pkg::EN_GLOBAL_BIT]) begin
         pend[intc_pkg::SRC_EXT0] = ext_flag[0] && src_en[0];
         pend[intc_pkg::SRC_T0]   = q.t0_flag && src_en[1];
         pend[intc_pkg::SRC_EXT1] = ext_flag[1] && src_en[2];
         pend[intc_pkg::SRC_T1]   = q.t1_flag && src_en[3];
         pend[intc_pkg::SRC_SER]  = (q.rx_flag || q.tx_flag) && src_en[4];
         pend[intc_pkg::SRC_T2]   = (q.t2ov_flag || q.t2ex_flag) && src_en[5];
         pend[intc_pkg::SRC_EXT2] = ext_flag[2] && src_en[6];
         pend[intc_pkg::SRC_EXT3] = ext_flag[3] && src_en[7];
      end
      // Level is {high,low}; 3 means highest
      for (int i = 0; i < 6; i++) begin
         level[2*i +: 2] = {q.prio_high[i], q.prio_low[i]};
      end
      level[2*intc_pkg::SRC_EXT2 +: 2] = {q.prio_high[6],
                                          q.ext_ctrl[intc_pkg::XC_EXT2_LSB + intc_pkg::XC_PRIO_BIT]};
      level[2*intc_pkg::SRC_EXT3 +: 2] = {q.prio_high[7],
                                          q.ext_ctrl[intc_pkg::XC_EXT3_LSB + intc_pkg::XC_PRIO_BIT]};
      busy = |q.in_service;
      floor_lvl = top_level(q.in_service);
   end

   intc_arbiter #(
      .N       (NSRC)
   ) u_arb (
      .pend_i  (pend),
      .level_i (level),
      .busy_i  (busy),
      .floor_i (floor_lvl),
      .win_o   (win)
   );

   always_comb begin
      d = q;
      d.ack = 1'b0;
      d.pin_prev = ext_int_n_i;

      // Hardware flag sets; these win over any clear in the same cycle
      if (timer0_ovf_i) begin
         d.t0_flag = 1'b1;
      end
      // Software writes act before hardware sets and clears
      if (wr && adr_i == intc_pkg::ADDR_ENABLE) begin
         d.enable = lane_byte(q.enable, dat_i, sel_i) & intc_pkg::ENABLE_MASK;
      end else if (wr && adr_i == intc_pkg::ADDR_PRIO_LOW) begin
         d.prio_low = lane_byte(q.prio_low, dat_i, sel_i) & intc_pkg::PRIO_LOW_MASK;
      end else if (wr && adr_i == intc_pkg::ADDR_PRIO_HIGH) begin
         d.prio_high = lane_byte(q.prio_high, dat_i, sel_i);
      end else if (wr && adr_i == intc_pkg::ADDR_EXT_CTRL) begin
         d.ext_ctrl = lane_byte(q.ext_ctrl, dat_i, sel_i);
      end else if (wr && adr_i == intc_pkg::ADDR_FLAGS) begin
         {d.t2ex_flag, d.t2ov_flag, d.tx_flag, d.rx_flag, d.ext01_type, d.t1_flag, d.t0_flag,
          d.ext01_flag} = wb16[9:0];
      end else if (wr && adr_i == intc_pkg::ADDR_EVT_STAT) begin
         d.evt_stat = q.evt_stat & ~wb0[1:0];
      end else if (wr && adr_i == intc_pkg::ADDR_EVT_MASK) begin
         d.evt_mask = 2'(lane_byte({6'h00, q.evt_mask}, dat_i, sel_i));
      end

      // External request flags
      for (int i = 0; i < 4; i++) begin
         logic nf;
         nf = ext_flag[i];
         if (i < 2) begin
            nf = d.ext01_flag[i];
         end else begin
            nf = d.ext_ctrl[intc_pkg::XC_EXT2_LSB + 4*(i-2) + intc_pkg::XC_FLAG_BIT];
         end
         if (!ext_type[i]) begin
            nf = !ext_int_n_i[i]; // Pin owns the flag in level mode
         end else if (q.pin_prev[i] && !ext_int_n_i[i]) begin
            nf = 1'b1;
         end
         if (i < 2) begin
            d.ext01_flag[i] = nf;
         end else begin
            d.ext_ctrl[intc_pkg::XC_EXT2_LSB + 4*(i-2) + intc_pkg::XC_FLAG_BIT] = nf;
         end
      end

      if (timer0_ovf_i) begin
         d.t0_flag = 1'b1;
      end
      if (timer1_ovf_i) begin
         d.t1_flag = 1'b1;
      end
      if (timer2_ovf_i) begin
         d.t2ov_flag = 1'b1;
      end
      if (timer2_ext_i) begin
         d.t2ex_flag = 1'b1;
      end
      if (rx_done_i) begin
         d.rx_flag = 1'b1;
      end
      if (tx_done_i) begin
         d.tx_flag = 1'b1;
      end

      // Grant sequencing, one vector at a time
      case (q.state)
         intc_pkg::ST_IDLE, intc_pkg::ST_SERVE: begin
            if (win.valid) begin
               d.state = intc_pkg::ST_OFFER;
               d.cur_src = win.src;
               d.core.req = 1'b1;
               d.core.vector = intc_pkg::VEC_BASE + 8'({5'h00, win.src} * intc_pkg::VEC_STEP);
               d.core.level = win.level;
            end
         end
         intc_pkg::ST_OFFER: begin
            if (core_ack_i) begin
               d.core.req = 1'b0;
               d.state = intc_pkg::ST_SERVE;
               d.in_service[q.core.level] = 1'b1;
               d.evt_stat[intc_pkg::EV_GRANT] = 1'b1;
               // Vectoring clears edge and timer 0/1 flags only
               if (q.cur_src == 3'(intc_pkg::SRC_T0) && !timer0_ovf_i) begin
                  d.t0_flag = 1'b0;
               end else if (q.cur_src == 3'(intc_pkg::SRC_T1) && !timer1_ovf_i) begin
                  d.t1_flag = 1'b0;
               end else if (q.cur_src == 3'(intc_pkg::SRC_EXT0) && ext_type[0]
                            && !(q.pin_prev[0] && !ext_int_n_i[0])) begin
                  d.ext01_flag[0] = 1'b0;
               end else if (q.cur_src == 3'(intc_pkg::SRC_EXT1) && ext_type[1]
                            && !(q.pin_prev[1] && !ext_int_n_i[1])) begin
                  d.ext01_flag[1] = 1'b0;
               end else if (q.cur_src == 3'(intc_pkg::SRC_EXT2) && ext_type[2]
                            && !(q.pin_prev[2] && !ext_int_n_i[2])) begin
                  d.ext_ctrl[intc_pkg::XC_EXT2_LSB + intc_pkg::XC_FLAG_BIT] = 1'b0;
               end else if (q.cur_src == 3'(intc_pkg::SRC_EXT3) && ext_type[3]
                            && !(q.pin_prev[3] && !ext_int_n_i[3])) begin
                  d.ext_ctrl[intc_pkg::XC_EXT3_LSB + intc_pkg::XC_FLAG_BIT] = 1'b0;
               end
            end else if (!win.valid || win.src != q.cur_src) begin
               // Request vanished or was overtaken before the core took it
               d.core.req = 1'b0;
               d.state = busy ? intc_pkg::ST_SERVE : intc_pkg::ST_IDLE;
            end
         end
         default: begin
            d.state = intc_pkg::ST_IDLE;
         end
      endcase

      // Return from routine retires the top in-service level
      if (core_reti_i && q.state != intc_pkg::ST_OFFER && busy) begin
         d.in_service[floor_lvl] = 1'b0;
         d.evt_stat[intc_pkg::EV_RETI] = 1'b1;
         // An offer raised in this same cycle keeps its state, else req would stand outside OFFER
         if (d.in_service == 4'h0 && d.state == intc_pkg::ST_SERVE) begin
            d.state = intc_pkg::ST_IDLE;
         end
      end

      // Register reads answer one cycle after request; unmapped reads as zero
      d.rdata = 32'h0000_0000;
      if (rd) begin
         if (adr_i == intc_pkg::ADDR_ENABLE) begin
            d.rdata[7:0] = q.enable;
         end else if (adr_i == intc_pkg::ADDR_PRIO_LOW) begin
            d.rdata[7:0] = q.prio_low;
         end else if (adr_i == intc_pkg::ADDR_PRIO_HIGH) begin
            d.rdata[7:0] = q.prio_high;
         end else if (adr_i == intc_pkg::ADDR_EXT_CTRL) begin
            d.rdata[7:0] = q.ext_ctrl;
         end else if (adr_i == intc_pkg::ADDR_FLAGS) begin
            d.rdata[9:0] = {q.t2ex_flag, q.t2ov_flag, q.tx_flag, q.rx_flag, q.ext01_type,
                            q.t1_flag, q.t0_flag, q.ext01_flag};
         end else if (adr_i == intc_pkg::ADDR_CORE) begin
            d.rdata[13:0] = {q.core.req, q.cur_src, q.state, q.in_service, q.core.level, busy, 1'b0};
         end else if (adr_i == intc_pkg::ADDR_EVT_STAT) begin
            d.rdata[1:0] = q.evt_stat;
         end else if (adr_i == intc_pkg::ADDR_EVT_MASK) begin
            d.rdata[1:0] = q.evt_mask;
         end
      end
      if (cyc_i && stb_i && !q.ack) begin
         d.ack = 1'b1;
      end
      d.irq = |(d.evt_stat & d.evt_mask);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.enable <= intc_pkg::RST_ENABLE;
         q.prio_low <= intc_pkg::RST_PRIO_LOW;
         q.prio_high <= intc_pkg::RST_PRIO_HIGH;
         q.ext_ctrl <= intc_pkg::RST_EXT_CTRL;
         q.evt_mask <= intc_pkg::RST_EVT_MASK[1:0];
         q.pin_prev <= 4'hf;
         q.state <= intc_pkg::ST_IDLE;
      end else begin
         q <= d;
      end
   end

   assign dat_o = q.rdata;
   assign ack_o = q.ack;
   assign core_o = q.core;
   assign irq_o = q.irq;

endmodule

/* File: tb/intc_top_asserts.sv */
// Port-level assertions for the interrupt controller
`timescale 1ns/100ps
module intc_top_asserts #(
   parameter int NSRC = 8
) (
   // Clock, reset and bus
   input wire logic                clk_i,
   input wire logic                rst_i,
   input wire logic                cyc_i,
   input wire logic                stb_i,
   input wire logic [31:0]         dat_o,
   input wire logic                ack_o,
   // Core handshake and event line
   input wire logic                core_ack_i,
   input wire logic                core_reti_i,
   input wire intc_pkg::core_req_t core_o,
   input wire logic                irq_o
);
   // Levels taken and not yet retired; a reti outside an offer retires the top one
   logic [3:0] svc_q;
   logic [3:0] svc_d;
   function automatic logic [3:0] drop_top(input logic [3:0] v);
      for (int i = 3; i >= 0; i--) begin
         if (v[i]) return v & ~(4'h1 << i);
      end
      return v;
   endfunction
   always_comb begin
      svc_d = svc_q;
      if (core_o.req && core_ack_i) svc_d = svc_q | (4'h1 << core_o.level);
      else if (core_reti_i && !core_o.req) svc_d = drop_top(svc_q);
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) svc_q <= 4'h0;
      else svc_q <= svc_d;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("bus request not acknowledged in one cycle");
   a_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("bus acknowledge longer than one cycle");
   a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("acknowledge without a request");
   a_data_idle: assert property (!ack_o |-> dat_o == 32'h0)
      else $error("read data not zero outside acknowledge");
   a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !ack_o && !core_o.req && !irq_o)
      else $error("outputs active after reset edge");
   a_vector_map: assert property (core_o.req |-> core_o.vector[2:0] == 3'h3 && core_o.vector[7:6] == 2'h0)
      else $error("offered vector outside the vector table");
   a_taken_drops: assert property (core_o.req && core_ack_i |=> !core_o.req)
      else $error("offer still up after the core took it");
   a_offer_stable: assert property (core_o.req && $past(core_o.req) |-> $stable(core_o.vector) && $stable(core_o.level))
      else $error("offered vector changed while held");
   a_above_service: assert property (core_o.req |-> (svc_q >> core_o.level) == 4'h0)
      else $error("offer not above the level in service");
endmodule
bind intc_top intc_top_asserts #(.NSRC(NSRC)) u_asserts (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .core_ack_i(core_ack_i), .core_reti_i(core_reti_i),
   .core_o(core_o), .irq_o(irq_o));

/* File: tb/core_model.sv */
// Core-side model: takes offered vectors after a set delay and logs them
`timescale 1ns/100ps
module core_model (
   // Clock and reset
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   // Controller side
   input  wire intc_pkg::core_req_t core_i,
   output logic                     core_ack_o,
   // Bench side
   input  wire logic [3:0]          delay_i,
   output logic [7:0]               taken_vec_o,
   output logic [1:0]               taken_lvl_o,
   output logic [7:0]               taken_cnt_o
);
   logic [3:0] wait_q;
   logic       cool_q;
   // One cycle of rest after each take, so a dropping offer is never acked twice
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         core_ack_o  <= 1'b0;
         wait_q      <= 4'h0;
         cool_q      <= 1'b0;
         taken_vec_o <= 8'h00;
         taken_lvl_o <= 2'h0;
         taken_cnt_o <= 8'h00;
      end else begin
         core_ack_o <= 1'b0;
         cool_q     <= 1'b0;
         if (core_ack_o && core_i.req) begin
            taken_vec_o <= core_i.vector;
            taken_lvl_o <= core_i.level;
            taken_cnt_o <= taken_cnt_o + 8'h01;
            cool_q      <= 1'b1;
         end else if (core_i.req && !core_ack_o && !cool_q) begin
            if (wait_q >= delay_i) begin
               core_ack_o <= 1'b1;
               wait_q     <= 4'h0;
            end else wait_q <= wait_q + 4'h1;
         end else wait_q <= 4'h0;
      end
   end
endmodule

/* File: tb/test_intc_top.sv */
// Self-checking bench for the interrupt controller
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin err_total++; \
   $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module test_intc_top;
   logic                clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, reti = 1'b0;
   logic [7:0]          adr_i = 8'h00, tvec, tcnt, seen = 8'h00;
   logic [3:0]          sel_i = 4'h0, ext_n = 4'hf, delay = 4'h2;
   logic [31:0]         dat_i = 32'h0, dat_o, rd;
   logic [5:0]          pls = 6'h00;
   logic [1:0]          tlvl;
   logic                ack_o, core_ack, irq_o;
   intc_pkg::core_req_t core_o;
   logic [7:0]          msk [3] = '{8'hbf, 8'h3f, 8'hff};
   logic [7:0]          off [2] = '{8'hbd, 8'h3f};
   int                  err_total = 0, total_checks = 0;
   always #10 clk_i = ~clk_i;
   intc_top #(.NSRC(8)) DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .ext_int_n_i(ext_n),
      .timer0_ovf_i(pls[5]), .timer1_ovf_i(pls[4]), .timer2_ovf_i(pls[3]), .timer2_ext_i(pls[2]),
      .rx_done_i(pls[1]), .tx_done_i(pls[0]), .core_ack_i(core_ack), .core_reti_i(reti), .core_o(core_o),
      .irq_o(irq_o));
   core_model partner (.clk_i(clk_i), .rst_i(rst_i), .core_i(core_o), .core_ack_o(core_ack), .delay_i(delay),
      .taken_vec_o(tvec), .taken_lvl_o(tlvl), .taken_cnt_o(tcnt));
   task automatic tally_and_finish;
      if (err_total == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      sel_i <= 4'h3;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1);
      rd = dat_o;
      // Acknowledge is registered, so it is seen at the second edge
      `CHK("bus ack", 2, n)
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] ex);
      wb(a, 1'b0, 32'h0);
      `CHK(nm, ex, rd)
   endtask
   // Waits for the core to take the next offer; the count, not timing, orders them
   task automatic take(input logic [7:0] v, input logic [1:0] l);
      int n;
      n = 0;
      while (tcnt === seen && n < 300) begin
         @(posedge clk_i);
         n++;
      end
      `CHK("takes", seen + 8'h01, tcnt)
      seen = tcnt;
      `CHK("vector", v, tvec)
      `CHK("level", l, tlvl)
   endtask
   task automatic ret;
      @(posedge clk_i);
      reti <= 1'b1;
      @(posedge clk_i);
      reti <= 1'b0;
   endtask
   task automatic pulse(input logic [5:0] p);
      @(posedge clk_i);
      pls <= p;
      @(posedge clk_i);
      pls <= 6'h00;
   endtask
   task automatic quiet;
      repeat (20) @(posedge clk_i);
      `CHK("no offer", 1'b0, core_o.req)
      `CHK("no take", seen, tcnt)
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      for (int i = 0; i < 4; i++) rdc("reset", 8'(4 * i), 32'h0);
      for (int i = 0; i < 3; i++) begin
         wb(8'(4 * i), 1'b1, 32'hff);
         rdc("bits", 8'(4 * i), {24'h0, msk[i]});
         wb(8'(4 * i), 1'b1, 32'h0);
      end
      wb(intc_pkg::ADDR_EXT_CTRL, 1'b1, 32'h99);
      rdc("ext ctrl", intc_pkg::ADDR_EXT_CTRL, 32'h99);
      wb(8'h20, 1'b1, 32'hff);
      rdc("unmapped", 8'h20, 32'h0);
      // All eight sources at one level, edge mode on every pin
      wb(intc_pkg::ADDR_EXT_CTRL, 1'b1, 32'h55);
      wb(intc_pkg::ADDR_FLAGS, 1'b1, 32'h30);
      wb(intc_pkg::ADDR_ENABLE, 1'b1, 32'hbf);
      ext_n <= 4'h0;
      pulse(6'h3f);
      for (int i = 0; i < 8; i++) begin
         take(8'h03 + 8'(8 * i), 2'h0);
         if (i == 4) begin
            rdc("flags", intc_pkg::ADDR_FLAGS, 32'h3f0);
            wb(intc_pkg::ADDR_FLAGS, 1'b1, 32'h330);
         end
         if (i == 5) begin
            rdc("flags", intc_pkg::ADDR_FLAGS, 32'h330);
            wb(intc_pkg::ADDR_FLAGS, 1'b1, 32'h30);
         end
         ret;
      end
      rdc("edge flags", intc_pkg::ADDR_EXT_CTRL, 32'h55);
      ext_n <= 4'hf;
      // A slow core, and timer 1 above timer 0
      delay <= 4'h5;
      wb(intc_pkg::ADDR_PRIO_HIGH, 1'b1, 32'h08);
      wb(intc_pkg::ADDR_PRIO_LOW, 1'b1, 32'h02);
      pulse(6'h30);
      take(8'h1b, 2'h2);
      pulse(6'h30);
      quiet;
      ret;
      take(8'h1b, 2'h2);
      ret;
      take(8'h0b, 2'h1);
      ret;
      rdc("events", intc_pkg::ADDR_EVT_STAT, 32'h3);
      `CHK("irq masked", 1'b0, irq_o)
      wb(intc_pkg::ADDR_EVT_MASK, 1'b1, 32'h1);
      `CHK("irq", 1'b1, irq_o)
      wb(intc_pkg::ADDR_EVT_STAT, 1'b1, 32'h3);
      `CHK("irq cleared", 1'b0, irq_o)
      for (int i = 0; i < 2; i++) begin
         wb(intc_pkg::ADDR_ENABLE, 1'b1, {24'h0, off[i]});
         pulse(6'h20);
         quiet;
      end
      wb(intc_pkg::ADDR_ENABLE, 1'b1, 32'hbf);
      take(8'h0b, 2'h1);
      ret;
      `CHK("irq grant", 1'b1, irq_o)
      // Level mode: the pin, not the grant, owns the flag
      wb(intc_pkg::ADDR_FLAGS, 1'b1, 32'h0);
      wb(intc_pkg::ADDR_ENABLE, 1'b1, 32'h81);
      ext_n <= 4'he;
      take(8'h03, 2'h0);
      ret;
      take(8'h03, 2'h0);
      ext_n <= 4'hf;
      @(posedge clk_i); // The flag follows the pin one edge later
      rdc("level flag", intc_pkg::ADDR_FLAGS, 32'h0);
      ret;
      quiet;
      tally_and_finish;
   end
   // Whole run is a few hundred cycles
   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      tally_and_finish;
   end
endmodule
